/* rspm_pkg.sv */
// Constants, types and register map of the reset status and power mode controller.
package rspm_pkg;

   localparam int         REG_AW            = 4;
   localparam int         REG_DW            = 8;

   localparam logic [3:0] ADDR_STAT_WDT     = 4'h0;
   localparam logic [3:0] ADDR_PWR_CTRL0    = 4'h1;
   localparam logic [3:0] ADDR_PWR_CTRL1    = 4'h2;
   localparam logic [3:0] ADDR_SUPPLY_CFG   = 4'h3;
   localparam logic [3:0] ADDR_RECOV_EN     = 4'h4;

   localparam int         STAT_POR_BIT      = 7;
   localparam int         STAT_RECOV_BIT    = 6;
   localparam int         STAT_WDT_BIT      = 5;
   localparam int         STAT_EXT_BIT      = 4;
   localparam int         STAT_LOW_BIT      = 0;

   localparam int         CFG_BO_EN_BIT     = 0;
   localparam int         CFG_LOW_IE_BIT    = 1;

   localparam logic [7:0] SUPPLY_CFG_RST    = 8'h01;
   localparam logic [7:0] PWR_CTRL_RST      = 8'h00;
   localparam logic [7:0] RECOV_EN_RST      = 8'h00;
   localparam logic [7:0] WDT_CTRL_RST      = 8'h00;

   localparam int         CLK_PERIOD_NS     = 40;
   localparam int         EXT_MIN_NS        = 200;
   localparam int         EXT_MIN_CYC       = (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         RST_HOLD_NS       = 640;
   localparam int         RST_HOLD_CYC      = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         OSC_START_NS      = 1000;
   localparam int         OSC_START_CYC     = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         CNT_W             = 8;

   typedef enum logic [2:0] {
      RSPM_ST_RESET,
      RSPM_ST_RUN,
      RSPM_ST_IDLE,
      RSPM_ST_SLEEP,
      RSPM_ST_WAKE
   } rspm_state_t;

   typedef struct packed {
      logic [REG_AW-1:0] addr;
      logic [REG_DW-1:0] wdata;
      logic              wr;
      logic              rd;
   } rspm_bus_req_t;

   typedef struct packed {
      logic por;
      logic recov;
      logic wdt;
      logic ext;
   } rspm_cause_t;

endpackage : rspm_pkg

/* rspm_ctrl.sv */
// Reset source tracking, supply-low detection and power mode control.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
module rspm_ctrl
   import rspm_pkg::*;
#(
   parameter bit LOW_DET_PRESENT = 1'b1,
   parameter int N_RECOV         = 8,
   parameter int N_PERIPH        = 16
)(
   input  wire logic                mclk_in,
   input  wire logic                rst_n_in,
   input  wire rspm_bus_req_t       bus_in,
   output logic [REG_DW-1:0]        rdata_out,
   input  wire logic                ext_rst_n_in,
   input  wire logic [N_RECOV-1:0]  recov_pin_in,
   input  wire logic                supply_below_in,
   input  wire logic                brownout_trip_in,
   input  wire logic                wdt_timeout_in,
   input  wire logic                wdt_reset_mode_in,
   input  wire logic                irq_pending_in,
   input  wire logic                halt_exec_in,
   input  wire logic                sleep_exec_in,
   output logic [REG_DW-1:0]        wdt_ctrl_out,
   output logic                     wdt_ctrl_wr_out,
   output logic                     sys_rst_n_out,
   output logic                     cpu_run_out,
   output logic                     idle_out,
   output logic                     sleep_out,
   output logic                     osc_en_out,
   output logic                     sysclk_en_out,
   output logic                     wdt_osc_en_out,
   output logic                     irq_resume_out,
   output logic                     recov_done_out,
   output logic                     brownout_en_out,
   output logic                     supply_low_irq_out,
   output logic [N_PERIPH-1:0]      periph_en_out
);

   // Wider pin or peripheral sets have no register bits behind them, so they are refused.
   if (N_RECOV < 1 || N_RECOV > REG_DW)
   begin : g_bad_recov
      $error("rspm_ctrl: N_RECOV must be 1 to 8");
   end
   if (N_PERIPH < 1 || N_PERIPH > 2 * REG_DW)
   begin : g_bad_periph
      $error("rspm_ctrl: N_PERIPH must be 1 to 16");
   end
   // The mode counter saturates at all ones and the filter counter at EXT_MIN_CYC, so every timing count must fit the counter width.
   if (EXT_MIN_CYC < 1 || EXT_MIN_CYC >= 2**CNT_W)
   begin : g_bad_ext
      $error("rspm_ctrl: EXT_MIN_CYC does not fit the filter counter");
   end
   if (RST_HOLD_CYC < 1 || RST_HOLD_CYC > 2**CNT_W)
   begin : g_bad_hold
      $error("rspm_ctrl: RST_HOLD_CYC does not fit the mode counter");
   end
   if (OSC_START_CYC < 1 || OSC_START_CYC > 2**CNT_W)
   begin : g_bad_osc
      $error("rspm_ctrl: OSC_START_CYC does not fit the mode counter");
   end

   function automatic logic hit(input rspm_bus_req_t req, input logic [REG_AW-1:0] off);
      hit = (req.addr == off);
   endfunction : hit

   // Pins and analogue comparators are asynchronous; each passes two flops first.
   logic [N_RECOV-1:0] recov_s1_q;
   logic [N_RECOV-1:0] recov_s2_q;
   logic               ext_s1_q;
   logic               ext_s2_q;
   logic               below_s1_q;
   logic               below_s2_q;
   logic               bo_s1_q;
   logic               bo_s2_q;

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         recov_s1_q <= '0;
         recov_s2_q <= '0;
         ext_s1_q   <= 1'b1;
         ext_s2_q   <= 1'b1;
         below_s1_q <= 1'b0;
         below_s2_q <= 1'b0;
         bo_s1_q    <= 1'b0;
         bo_s2_q    <= 1'b0;
      end
      else
      begin
         recov_s1_q <= recov_pin_in;
         recov_s2_q <= recov_s1_q;
         ext_s1_q   <= ext_rst_n_in;
         ext_s2_q   <= ext_s1_q;
         below_s1_q <= supply_below_in;
         below_s2_q <= below_s1_q;
         bo_s1_q    <= brownout_trip_in;
         bo_s2_q    <= bo_s1_q;
      end
   end

   // Registers written by software.
   logic [7:0] pwr_ctrl0_q;
   logic [7:0] pwr_ctrl1_q;
   logic [7:0] supply_cfg_q;
   logic [7:0] recov_en_q;
   logic [7:0] wdt_ctrl_q;
   logic       wdt_wr_q;

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         pwr_ctrl0_q  <= PWR_CTRL_RST;
         pwr_ctrl1_q  <= PWR_CTRL_RST;
         supply_cfg_q <= SUPPLY_CFG_RST;
         recov_en_q   <= RECOV_EN_RST;
         wdt_ctrl_q   <= WDT_CTRL_RST;
         wdt_wr_q     <= 1'b0;
      end
      else
      begin
         wdt_wr_q <= bus_in.wr && hit(bus_in, ADDR_STAT_WDT);
         if (bus_in.wr)
         begin
            if (hit(bus_in, ADDR_STAT_WDT))
               wdt_ctrl_q <= bus_in.wdata;
            if (hit(bus_in, ADDR_PWR_CTRL0))
               pwr_ctrl0_q <= bus_in.wdata;
            if (hit(bus_in, ADDR_PWR_CTRL1))
               pwr_ctrl1_q <= bus_in.wdata;
            if (hit(bus_in, ADDR_SUPPLY_CFG))
               supply_cfg_q <= bus_in.wdata;
            if (hit(bus_in, ADDR_RECOV_EN))
               recov_en_q <= bus_in.wdata;
         end
      end
   end

   // Supply-low path follows the two-flop synchronised comparator with no sticky bit, so it cannot be latched.
   logic bo_en;
   logic supply_low;
   assign bo_en      = supply_cfg_q[CFG_BO_EN_BIT];
   if (LOW_DET_PRESENT)
   begin : g_low_det
      assign supply_low = bo_en && below_s2_q;
   end
   else
   begin : g_no_low_det
      // Larger packages have no comparator, so the flag and its interrupt stay zero.
      assign supply_low = 1'b0;
   end

   logic [2*REG_DW-1:0] pwr_all;
   assign pwr_all = {pwr_ctrl1_q, pwr_ctrl0_q};

   // Reset pin glitch filter: counts consecutive low cycles of the synchronised pin.
   logic [CNT_W-1:0] ext_cnt_q;
   logic             ext_event;

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         ext_cnt_q <= '0;
      else if (ext_s2_q)
         ext_cnt_q <= '0;
      else if (ext_cnt_q != CNT_W'(EXT_MIN_CYC))
         ext_cnt_q <= ext_cnt_q + CNT_W'(1);
   end

   assign ext_event = !ext_s2_q && (ext_cnt_q == CNT_W'(EXT_MIN_CYC - 1));

   // Mode sequencer.
   rspm_state_t      state_q;
   rspm_state_t      state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [N_RECOV-1:0] snap_q;
   logic             bo_event;
   logic             wdt_rst_event;
   logic             wdt_irq_event;
   logic             any_rst;
   logic             recov_event;

   assign bo_event      = bo_en && bo_s2_q;
   assign wdt_rst_event = wdt_timeout_in && wdt_reset_mode_in;
   assign wdt_irq_event = wdt_timeout_in && !wdt_reset_mode_in;
   assign any_rst       = bo_event || wdt_rst_event || ext_event;
   // A change on an enabled pin wakes directly; no port data register or interrupt is needed.
   assign recov_event   = (state_q == RSPM_ST_SLEEP)
                          && |((recov_s2_q ^ snap_q) & recov_en_q[N_RECOV-1:0]);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         RSPM_ST_RESET:
            if (cnt_q == CNT_W'(RST_HOLD_CYC - 1))
               state_d = RSPM_ST_RUN;
         RSPM_ST_RUN:
            if (sleep_exec_in)
               state_d = RSPM_ST_SLEEP;
            else if (halt_exec_in)
               state_d = RSPM_ST_IDLE;
         RSPM_ST_IDLE:
            if (irq_pending_in || wdt_irq_event)
               state_d = RSPM_ST_RUN;
         RSPM_ST_SLEEP:
            if (recov_event || wdt_irq_event)
               state_d = RSPM_ST_WAKE;
         RSPM_ST_WAKE:
            if (cnt_q == CNT_W'(OSC_START_CYC - 1))
               state_d = RSPM_ST_RUN;
         default:
            state_d = RSPM_ST_RESET;
      endcase
      // Any reset source overrides every mode, so an ext pin in sleep never looks like recovery.
      if (any_rst)
         state_d = RSPM_ST_RESET;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         state_q <= RSPM_ST_RESET;
      else
         state_q <= state_d;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         cnt_q <= '0;
      else if (state_d != state_q || any_rst)
         cnt_q <= '0;
      else if (cnt_q != {CNT_W{1'b1}})
         cnt_q <= cnt_q + CNT_W'(1);
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         snap_q <= '0;
      else if (state_q != RSPM_ST_SLEEP)
         snap_q <= recov_s2_q;
   end

   // Resume and recovery strobes.
   logic irq_resume_q;
   logic recov_done_q;

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         irq_resume_q <= 1'b0;
         recov_done_q <= 1'b0;
      end
      else
      begin
         irq_resume_q <= (state_q == RSPM_ST_IDLE) && (state_d == RSPM_ST_RUN);
         recov_done_q <= (state_q == RSPM_ST_WAKE) && (state_d == RSPM_ST_RUN);
      end
   end

   // Status: events set, a status read clears the upper four bits, and a set wins.
   rspm_cause_t cause_q;
   logic        stat_rd;
   assign stat_rd = bus_in.rd && hit(bus_in, ADDR_STAT_WDT);

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         cause_q <= '{por: 1'b1, recov: 1'b0, wdt: 1'b0, ext: 1'b0};
      else
      begin
         // A brownout restart is reported with power-on, since both mean lost supply.
         if (bo_event)
            cause_q.por <= 1'b1;
         else if (any_rst || stat_rd)
            cause_q.por <= 1'b0;
         if (recov_event || (state_q == RSPM_ST_SLEEP && wdt_irq_event))
            cause_q.recov <= 1'b1;
         else if (any_rst || stat_rd)
            cause_q.recov <= 1'b0;
         if (wdt_timeout_in)
            cause_q.wdt <= 1'b1;
         else if ((any_rst && !wdt_rst_event) || stat_rd)
            cause_q.wdt <= 1'b0;
         if (ext_event)
            cause_q.ext <= 1'b1;
         else if (any_rst || stat_rd)
            cause_q.ext <= 1'b0;
      end
   end

   // Read data: one cycle after the strobe; unmapped addresses read zero.
   logic [REG_DW-1:0] rdata_q;
   logic [REG_DW-1:0] rd_mux;

   always_comb
   begin
      rd_mux = '0;
      if (hit(bus_in, ADDR_STAT_WDT))
      begin
         rd_mux[STAT_POR_BIT]   = cause_q.por;
         rd_mux[STAT_RECOV_BIT] = cause_q.recov;
         rd_mux[STAT_WDT_BIT]   = cause_q.wdt;
         rd_mux[STAT_EXT_BIT]   = cause_q.ext;
         rd_mux[STAT_LOW_BIT]   = supply_low;
      end
      else if (hit(bus_in, ADDR_PWR_CTRL0))
         rd_mux = pwr_ctrl0_q;
      else if (hit(bus_in, ADDR_PWR_CTRL1))
         rd_mux = pwr_ctrl1_q;
      else if (hit(bus_in, ADDR_SUPPLY_CFG))
         rd_mux = supply_cfg_q;
      else if (hit(bus_in, ADDR_RECOV_EN))
         rd_mux = recov_en_q;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
         rdata_q <= '0;
      else if (bus_in.rd)
         rdata_q <= rd_mux;
      else
         rdata_q <= '0;
   end

   // Outputs.
   assign rdata_out          = rdata_q;
   assign wdt_ctrl_out       = wdt_ctrl_q;
   assign wdt_ctrl_wr_out    = wdt_wr_q;
   assign sys_rst_n_out      = (state_q != RSPM_ST_RESET);
   assign cpu_run_out        = (state_q == RSPM_ST_RUN);
   assign idle_out           = (state_q == RSPM_ST_IDLE);
   assign sleep_out          = (state_q == RSPM_ST_SLEEP);
   // Only sleep stops the oscillator; sleep and wake stop the system clock; idle keeps both.
   assign osc_en_out         = (state_q != RSPM_ST_SLEEP);
   assign sysclk_en_out      = (state_q != RSPM_ST_SLEEP) && (state_q != RSPM_ST_WAKE);
   assign wdt_osc_en_out     = 1'b1;
   assign irq_resume_out     = irq_resume_q;
   assign recov_done_out     = recov_done_q;
   assign brownout_en_out    = bo_en;
   assign supply_low_irq_out = supply_low && supply_cfg_q[CFG_LOW_IE_BIT];
   // Peripheral enables ignore the mode, so idle leaves them untouched.
   assign periph_en_out      = ~pwr_all[N_PERIPH-1:0];

endmodule : rspm_ctrl

/* rspm_ext_drv.sv */
// Board-level driver model for the external reset pin.
`timescale 1ns/10ps
module rspm_ext_drv (
   input  wire logic mclk_in,
   output logic      ext_rst_n_out
);
   // The pin has a pull-up, so a released pin reads high.
   initial ext_rst_n_out = 1'b1;

   // Low pulse of n clock cycles, launched just after a rising edge.
   task automatic pulse(input int n);
      @(posedge mclk_in);
      ext_rst_n_out <= 1'b0;
      repeat (n) @(posedge mclk_in);
      ext_rst_n_out <= 1'b1;
   endtask : pulse
endmodule : rspm_ext_drv

/* rspm_ctrl_chk.sv */
// Port-level assertions for the reset status and power mode controller.
`timescale 1ns/10ps
module rspm_ctrl_chk
   import rspm_pkg::*;
#(
   parameter int N_PERIPH = 16
)(
   input wire logic                mclk_in,
   input wire logic                rst_n_in,
   input wire rspm_bus_req_t       bus_in,
   input wire logic                ext_rst_n_in,
   input wire logic                supply_below_in,
   input wire logic                irq_pending_in,
   input wire logic                halt_exec_in,
   input wire logic                sleep_exec_in,
   input wire logic [REG_DW-1:0]   wdt_ctrl_out,
   input wire logic                wdt_ctrl_wr_out,
   input wire logic                sys_rst_n_out,
   input wire logic                cpu_run_out,
   input wire logic                idle_out,
   input wire logic                osc_en_out,
   input wire logic                sysclk_en_out,
   input wire logic                wdt_osc_en_out,
   input wire logic                irq_resume_out,
   input wire logic                brownout_en_out,
   input wire logic                supply_low_irq_out,
   input wire logic [N_PERIPH-1:0] periph_en_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   // The resume strobe rises with the first run cycle, since both come from one edge.
   sequence s_resume;
      cpu_run_out && irq_resume_out ##1 !irq_resume_out;
   endsequence
   // Four synced low cycles are still a glitch, so this is the longest ignored pulse.
   sequence s_glitch;
      sys_rst_n_out && ext_rst_n_in ##1 !ext_rst_n_in [*4] ##1 ext_rst_n_in;
   endsequence
   sequence s_pin_low;
      $fell(ext_rst_n_in) ##1 !ext_rst_n_in [*7];
   endsequence

   AST_WDT_WR: assert property (bus_in.wr && bus_in.addr == ADDR_STAT_WDT
      |=> wdt_ctrl_wr_out && wdt_ctrl_out == $past(bus_in.wdata))
      else $error("watchdog control write lost");
   AST_PERIPH: assert property (bus_in.wr && bus_in.addr == ADDR_PWR_CTRL0
      |=> periph_en_out[7:0] == ~$past(bus_in.wdata))
      else $error("peripheral enable mismatch");
   AST_LOW_BO: assert property (!brownout_en_out |-> !supply_low_irq_out)
      else $error("supply-low irq with brownout off");
   AST_LOW_IRQ: assert property (supply_low_irq_out |-> $past(supply_below_in, 2))
      else $error("supply-low irq without low supply");
   AST_IDLE_IN: assert property (cpu_run_out && halt_exec_in && !sleep_exec_in
      && !irq_pending_in |=> idle_out && !cpu_run_out)
      else $error("halt did not enter idle");
   AST_IDLE_CLK: assert property (idle_out
      |-> osc_en_out && sysclk_en_out && wdt_osc_en_out && !cpu_run_out)
      else $error("clocks stopped in idle");
   AST_IDLE_OUT: assert property (idle_out && irq_pending_in |=> s_resume)
      else $error("interrupt did not resume");
   AST_PIN_RST: assert property (s_pin_low |-> ##[0:3] !sys_rst_n_out)
      else $error("reset pin ignored");
   AST_GLITCH: assert property (s_glitch |-> sys_rst_n_out [*8])
      else $error("glitch caused reset");
endmodule : rspm_ctrl_chk

bind rspm_ctrl rspm_ctrl_chk #(.N_PERIPH(N_PERIPH)) u_chk (.mclk_in, .rst_n_in, .bus_in,
   .ext_rst_n_in, .supply_below_in, .irq_pending_in, .halt_exec_in, .sleep_exec_in,
   .wdt_ctrl_out, .wdt_ctrl_wr_out, .sys_rst_n_out, .cpu_run_out, .idle_out, .osc_en_out,
   .sysclk_en_out, .wdt_osc_en_out, .irq_resume_out, .brownout_en_out, .supply_low_irq_out,
   .periph_en_out);

/* reset_status_power_modes_tb_top.sv */
// Self-checking testbench for the reset status and power mode controller.
`timescale 1ns/10ps
module reset_status_power_modes_tb_top;
   import rspm_pkg::*;
   logic          mclk_in = 1'b0;
   logic          rst_n_in = 1'b0;
   rspm_bus_req_t bus_in = '0;
   logic [7:0]    recov_pin_in = 8'h00;
   logic          supply_below_in = 1'b0;
   logic          brownout_trip_in = 1'b0;
   logic          wdt_timeout_in = 1'b0;
   logic          wdt_reset_mode_in = 1'b0;
   logic          irq_pending_in = 1'b0;
   logic          halt_exec_in = 1'b0;
   logic          sleep_exec_in = 1'b0;
   logic          ext_rst_n_in, wdt_ctrl_wr_out, sys_rst_n_out, cpu_run_out, idle_out;
   logic          sleep_out, osc_en_out, sysclk_en_out, wdt_osc_en_out, irq_resume_out;
   logic          recov_done_out, brownout_en_out, supply_low_irq_out;
   logic [7:0]    rdata_out, wdt_ctrl_out;
   logic [15:0]   periph_en_out;
   int            failures = 0;
   int            num_checks = 0;
   int            n_res = 0;
   int            n_rec = 0;

   always #20 mclk_in = ~mclk_in;

   rspm_ext_drv drv (.mclk_in, .ext_rst_n_out(ext_rst_n_in));
   rspm_ctrl uut (.mclk_in, .rst_n_in, .bus_in, .rdata_out, .ext_rst_n_in, .recov_pin_in,
      .supply_below_in, .brownout_trip_in, .wdt_timeout_in, .wdt_reset_mode_in, .irq_pending_in,
      .halt_exec_in, .sleep_exec_in, .wdt_ctrl_out, .wdt_ctrl_wr_out, .sys_rst_n_out,
      .cpu_run_out, .idle_out, .sleep_out, .osc_en_out, .sysclk_en_out, .wdt_osc_en_out,
      .irq_resume_out, .recov_done_out, .brownout_en_out, .supply_low_irq_out, .periph_en_out);

   // Pulses are counted because they stand for one cycle only.
   always @(posedge mclk_in)
   begin
      n_res += int'(irq_resume_out === 1'b1);
      n_rec += int'(recov_done_out === 1'b1);
   end

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      bus_in.addr <= a;
      bus_in.wdata <= d;
      bus_in.wr <= 1'b1;
      @(posedge mclk_in);
      bus_in.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      bus_in.addr <= a;
      bus_in.rd <= 1'b1;
      @(posedge mclk_in);
      bus_in.rd <= 1'b0;
      #1 chk(nm, 16'(rdata_out), 16'(e));
   endtask : rdc

   task automatic hit(input logic h, input logic s, input logic w);
      @(posedge mclk_in);
      halt_exec_in <= h;
      sleep_exec_in <= s;
      wdt_timeout_in <= w;
      @(posedge mclk_in);
      halt_exec_in <= 1'b0;
      sleep_exec_in <= 1'b0;
      wdt_timeout_in <= 1'b0;
   endtask : hit

   task automatic wait_run();
      for (int i = 0; i < 200 && cpu_run_out !== 1'b1; i++)
         cyc(1);
      chk("run", 16'(cpu_run_out), 16'h1);
   endtask : wait_run

   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (10) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      rdc("stat_por", ADDR_STAT_WDT, 8'h80);
      rdc("stat_clr", ADDR_STAT_WDT, 8'h00);
      rdc("unmapped", 4'hf, 8'h00);
      rdc("cfg", ADDR_SUPPLY_CFG, SUPPLY_CFG_RST);
      wait_run();
      wr(ADDR_PWR_CTRL0, 8'ha5);
      wr(ADDR_PWR_CTRL1, 8'h0f);
      chk("periph", periph_en_out, 16'hf05a);
      wr(ADDR_PWR_CTRL0, 8'h00);
      wr(ADDR_PWR_CTRL1, 8'h00);
      wr(ADDR_STAT_WDT, 8'h3c);
      chk("wdt_ctrl", 16'(wdt_ctrl_out), 16'h3c);
      chk("wdt_wr", 16'(wdt_ctrl_wr_out), 16'h1);
      rdc("stat_wr", ADDR_STAT_WDT, 8'h00);
      @(posedge mclk_in) supply_below_in <= 1'b1;
      wr(ADDR_SUPPLY_CFG, 8'h03);
      cyc(3);
      rdc("low_set", ADDR_STAT_WDT, 8'h01);
      wr(ADDR_STAT_WDT, 8'h01);
      rdc("low_kept", ADDR_STAT_WDT, 8'h01);
      chk("low_irq", 16'(supply_low_irq_out), 16'h1);
      @(posedge mclk_in) supply_below_in <= 1'b0;
      cyc(3);
      rdc("low_gone", ADDR_STAT_WDT, 8'h00);
      chk("irq_gone", 16'(supply_low_irq_out), 16'h0);
      wr(ADDR_SUPPLY_CFG, 8'h02);
      @(posedge mclk_in) supply_below_in <= 1'b1;
      brownout_trip_in <= 1'b1;
      cyc(3);
      rdc("low_bo_off", ADDR_STAT_WDT, 8'h00);
      chk("irq_bo_off", 16'(supply_low_irq_out), 16'h0);
      chk("bo_off", 16'({brownout_en_out, sys_rst_n_out}), 16'h1);
      @(posedge mclk_in) supply_below_in <= 1'b0;
      brownout_trip_in <= 1'b0;
      wr(ADDR_SUPPLY_CFG, 8'h01);
      hit(1'b1, 1'b0, 1'b0);
      cyc(1);
      chk("idle", 16'({idle_out, cpu_run_out, osc_en_out, sysclk_en_out, wdt_osc_en_out}),
         16'h17);
      chk("periph_idle", periph_en_out, 16'hffff);
      @(posedge mclk_in) irq_pending_in <= 1'b1;
      @(posedge mclk_in) irq_pending_in <= 1'b0;
      cyc(2);
      chk("resume", 16'(n_res), 16'h1);
      hit(1'b1, 1'b0, 1'b0);
      hit(1'b0, 1'b0, 1'b1);
      cyc(2);
      chk("wdt_exit", 16'(cpu_run_out), 16'h1);
      rdc("stat_wdt", ADDR_STAT_WDT, 8'h20);
      wr(ADDR_RECOV_EN, 8'h01);
      hit(1'b0, 1'b1, 1'b0);
      #1 chk("sleep", 16'({sleep_out, osc_en_out, sysclk_en_out}), 16'h4);
      @(posedge mclk_in) recov_pin_in <= 8'h01;
      cyc(5);
      chk("wake", 16'({sleep_out, osc_en_out, sysclk_en_out}), 16'h2);
      wait_run();
      cyc(2);
      chk("recov_done", 16'(n_rec), 16'h1);
      rdc("stat_recov", ADDR_STAT_WDT, 8'h40);
      drv.pulse(4);
      cyc(10);
      chk("glitch", 16'({sys_rst_n_out, cpu_run_out}), 16'h3);
      hit(1'b0, 1'b1, 1'b0);
      drv.pulse(8);
      cyc(2);
      chk("ext_rst", 16'(sys_rst_n_out), 16'h0);
      wait_run();
      rdc("stat_ext", ADDR_STAT_WDT, 8'h10);
      hit(1'b1, 1'b0, 1'b0);
      @(posedge mclk_in) brownout_trip_in <= 1'b1;
      cyc(4);
      chk("bo_rst", 16'({idle_out, sys_rst_n_out}), 16'h0);
      @(posedge mclk_in) brownout_trip_in <= 1'b0;
      wait_run();
      rdc("stat_bo", ADDR_STAT_WDT, 8'h80);
      @(posedge mclk_in) wdt_reset_mode_in <= 1'b1;
      hit(1'b1, 1'b0, 1'b0);
      hit(1'b0, 1'b0, 1'b1);
      cyc(1);
      chk("wdt_rst", 16'({idle_out, sys_rst_n_out}), 16'h0);
      wait_run();
      rdc("stat_wdt_rst", ADDR_STAT_WDT, 8'h20);
      end_of_test();
   end

   // The whole sequence needs well under a thousand cycles.
   initial
   begin
      #(40 * 4000);
      failures++;
      end_of_test();
   end
endmodule : reset_status_power_modes_tb_top
